// *** verilog/sdc_config_regs.sv ***
// Dither, charge pump and LO path configuration registers with field decode.
//
// Contract
// - Select code 011 writes dither register.
// - Size codes map to magnitudes 15,7,3,1.
// - Dither enable bit, reset on.
// - Seventeen-bit restart seed, reset one.
// - Select code 100 writes pump register.
// - Bits 11:10 current; bit 18 external resistor.
// - Bits 16:12 phase offset, reset ten.
// - Bit 17 sets phase offset sign.
// - Reference scaled by two, one, half, quarter.
// - Status pin selector, reset to lock detect.
// - Select code 101 writes LO path register.
// - Separate modulator bias and output enables; the code turns the output on only with the bias bit also set.
// - Input bit makes port 2x input; the code makes it an input only with the pin and drive bit low.
// - Otherwise drive gives 1x or 2x output.
`timescale 1ns/100ps
`default_nettype none
module sdc_config_regs (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic wordValid,
   input wire logic [sdc_pkg::WORD_W-1:0] wordData,
   input wire logic lo_port_select_pin,
   input wire logic [sdc_pkg::MUX_SRC_N-1:0] statusSources,
   output logic ditherOn,
   output logic [3:0] ditherMagnitude,
   output logic [sdc_pkg::DITH_SEED_W-1:0] ditherSeed,
   output logic [sdc_pkg::PUMP_CUR_W-1:0] pumpCurrentCode,
   output logic pumpUsesResistor,
   output logic [sdc_pkg::PHASE_OFS_W-1:0] phaseOffsetMult,
   output logic phaseOffsetNegative,
   output logic [sdc_pkg::REF_SCALE_W-1:0] refScaleCode,
   output logic refDoubleOn,
   output logic refDivideBy2On,
   output logic refDivideBy4On,
   output logic status_mux_pin,
   output logic modBiasOn,
   output logic modOutputOn,
   output logic loPortInputOn,
   output logic loPortOutputOn,
   output logic loPortOutputDouble,
   output logic foreignWord
);
   logic [sdc_pkg::WORD_W-1:0] ditherCtl_reg;
   logic [sdc_pkg::WORD_W-1:0] pumpCtl_reg;
   logic [sdc_pkg::WORD_W-1:0] loPathCtl_reg;
   logic [sdc_pkg::SEL_W-1:0] wordSel;
   logic hitDither;
   logic hitPump;
   logic hitLoPath;
   logic [1:0] ditherSize;
   logic [sdc_pkg::MUX_SEL_W-1:0] muxSel;

   // Decode the target from the low three bits of the word.
   assign wordSel = wordData[sdc_pkg::SEL_W-1:0];
   assign hitDither = wordValid && (wordSel == sdc_pkg::SEL_DITHER);
   assign hitPump = wordValid && (wordSel == sdc_pkg::SEL_PUMP);
   assign hitLoPath = wordValid && (wordSel == sdc_pkg::SEL_LOPATH);

   // Dither register; the whole word is stored so the select bits read back as 011.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ditherCtl_reg <= sdc_pkg::DITHER_RST;
      end else if (hitDither) begin
         ditherCtl_reg <= wordData;
      end
   end

   // Pump, detector and reference path register.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pumpCtl_reg <= sdc_pkg::PUMP_RST;
      end else if (hitPump) begin
         pumpCtl_reg <= wordData;
      end
   end

   // LO path and modulator register.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         loPathCtl_reg <= sdc_pkg::LOPATH_RST;
      end else if (hitLoPath) begin
         loPathCtl_reg <= wordData;
      end
   end

   // Codes owned by other register banks are flagged for one cycle and dropped here.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         foreignWord <= 1'b0;
      end else begin
         foreignWord <= wordValid & ~(hitDither | hitPump | hitLoPath);
      end
   end

   assign ditherSize = {ditherCtl_reg[sdc_pkg::DITH_SIZE_HI], ditherCtl_reg[sdc_pkg::DITH_SIZE_LO]};

   // Dither fields; magnitude is decoded here so the modulator sees plain numbers.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ditherOn <= 1'b0;
         ditherMagnitude <= sdc_pkg::DITH_MAG_0;
         ditherSeed <= '0;
      end else begin
         ditherOn <= ditherCtl_reg[sdc_pkg::DITH_ON_BIT];
         ditherSeed <= ditherCtl_reg[sdc_pkg::DITH_SEED_LSB +: sdc_pkg::DITH_SEED_W];
         case (ditherSize)
            2'h0: ditherMagnitude <= sdc_pkg::DITH_MAG_0;
            2'h1: ditherMagnitude <= sdc_pkg::DITH_MAG_1;
            2'h2: ditherMagnitude <= sdc_pkg::DITH_MAG_2;
            default: ditherMagnitude <= sdc_pkg::DITH_MAG_3;
         endcase
      end
   end

   // Pump and phase detector fields.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pumpCurrentCode <= '0;
         pumpUsesResistor <= 1'b0;
         phaseOffsetMult <= '0;
         phaseOffsetNegative <= 1'b0;
      end else begin
         pumpCurrentCode <= pumpCtl_reg[sdc_pkg::PUMP_CUR_LSB +: sdc_pkg::PUMP_CUR_W];
         pumpUsesResistor <= pumpCtl_reg[sdc_pkg::PUMP_RES_BIT];
         phaseOffsetMult <= pumpCtl_reg[sdc_pkg::PHASE_OFS_LSB +: sdc_pkg::PHASE_OFS_W];
         phaseOffsetNegative <= pumpCtl_reg[sdc_pkg::PHASE_SIGN_BIT];
      end
   end

   // Reference scaling; exactly one of the three path controls is set, none for 1x.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         refScaleCode <= sdc_pkg::REF_X1;
         refDoubleOn <= 1'b0;
         refDivideBy2On <= 1'b0;
         refDivideBy4On <= 1'b0;
      end else begin
         refScaleCode <= pumpCtl_reg[sdc_pkg::REF_SCALE_LSB +: sdc_pkg::REF_SCALE_W];
         refDoubleOn <= 1'b0;
         refDivideBy2On <= 1'b0;
         refDivideBy4On <= 1'b0;
         case (pumpCtl_reg[sdc_pkg::REF_SCALE_LSB +: sdc_pkg::REF_SCALE_W])
            sdc_pkg::REF_X2: refDoubleOn <= 1'b1;
            sdc_pkg::REF_HALF: refDivideBy2On <= 1'b1;
            sdc_pkg::REF_QUARTER: refDivideBy4On <= 1'b1;
            default: refDoubleOn <= 1'b0;
         endcase
      end
   end

   assign muxSel = pumpCtl_reg[sdc_pkg::MUX_SEL_LSB +: sdc_pkg::MUX_SEL_W];

   // Status pin selector.
   sdc_status_mux statusMux (
      .sys_clk(sys_clk),
      .srst(srst),
      .muxSel(muxSel),
      .statusSources(statusSources),
      .status_mux_pin(status_mux_pin)
   );

   // Modulator enables; output is gated by bias since an unbiased stage cannot drive.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         modBiasOn <= 1'b0;
         modOutputOn <= 1'b0;
      end else begin
         modBiasOn <= loPathCtl_reg[sdc_pkg::MOD_BIAS_BIT];
         modOutputOn <= loPathCtl_reg[sdc_pkg::MOD_OUT_BIT] & loPathCtl_reg[sdc_pkg::MOD_BIAS_BIT];
      end
   end

   // LO port direction and multiplier.
   sdc_lo_port_mode loPortMode (
      .sys_clk(sys_clk),
      .srst(srst),
      .lo_port_select_pin(lo_port_select_pin),
      .lo_port_drive(loPathCtl_reg[sdc_pkg::LO_DRIVE_BIT]),
      .lo_port_as_input(loPathCtl_reg[sdc_pkg::LO_INPUT_BIT]),
      .lo_double_choice(loPathCtl_reg[sdc_pkg::LO_DOUBLE_BIT]),
      .loPortInputOn(loPortInputOn),
      .loPortOutputOn(loPortOutputOn),
      .loPortOutputDouble(loPortOutputDouble)
   );
endmodule
`default_nettype wire

// *** verilog/sdc_pkg.sv ***
// Constants for the dither, pump and LO path configuration registers.
package sdc_pkg;
   localparam int WORD_W = 24;
   localparam int SEL_W = 3;
   // Three-bit select codes carried in the low bits of every word.
   localparam logic [2:0] SEL_DITHER = 3'h3;
   localparam logic [2:0] SEL_PUMP = 3'h4;
   localparam logic [2:0] SEL_LOPATH = 3'h5;
   // Reset images of the three registers.
   localparam logic [23:0] DITHER_RST = 24'h10000b;
   localparam logic [23:0] PUMP_RST = 24'h0aa7e4;
   localparam logic [23:0] LOPATH_RST = 24'h0000d5;
   // Dither register fields.
   localparam int DITH_SEED_LSB = 3;
   localparam int DITH_SEED_W = 17;
   localparam int DITH_ON_BIT = 20;
   localparam int DITH_SIZE_LO = 21;
   localparam int DITH_SIZE_HI = 22;
   // Dither magnitudes for size codes 00, 01, 10 and 11.
   localparam logic [3:0] DITH_MAG_0 = 4'hf;
   localparam logic [3:0] DITH_MAG_1 = 4'h7;
   localparam logic [3:0] DITH_MAG_2 = 4'h3;
   localparam logic [3:0] DITH_MAG_3 = 4'h1;
   // Pump, detector and reference path fields.
   localparam int MUX_SEL_LSB = 4;
   localparam int MUX_SEL_W = 3;
   localparam int PUMP_CUR_LSB = 10;
   localparam int PUMP_CUR_W = 2;
   localparam int PHASE_OFS_LSB = 12;
   localparam int PHASE_OFS_W = 5;
   localparam int PHASE_SIGN_BIT = 17;
   localparam int PUMP_RES_BIT = 18;
   localparam int REF_SCALE_LSB = 19;
   localparam int REF_SCALE_W = 2;
   // Reference scaling codes.
   localparam logic [1:0] REF_X2 = 2'h0;
   localparam logic [1:0] REF_X1 = 2'h1;
   localparam logic [1:0] REF_HALF = 2'h2;
   localparam logic [1:0] REF_QUARTER = 2'h3;
   // Status source that the reset value selects.
   localparam logic [2:0] MUX_LOCK_DETECT = 3'h6;
   localparam int MUX_SRC_N = 8;
   // LO path and modulator fields.
   localparam int LO_DRIVE_BIT = 3;
   localparam int LO_INPUT_BIT = 4;
   localparam int LO_DOUBLE_BIT = 5;
   localparam int MOD_BIAS_BIT = 6;
   localparam int MOD_OUT_BIT = 7;
endpackage

// *** verilog/sdc_lo_port_mode.sv ***
// LO port mode decode from the select pin and the three LO path bits.
`timescale 1ns/100ps
`default_nettype none
module sdc_lo_port_mode (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic lo_port_select_pin,
   input wire logic lo_port_drive,
   input wire logic lo_port_as_input,
   input wire logic lo_double_choice,
   output logic loPortInputOn,
   output logic loPortOutputOn,
   output logic loPortOutputDouble
);
   logic driveWanted;

   // The pin or the drive bit asks for output; with the input bit also set, the port is neither input nor output.
   assign driveWanted = lo_port_select_pin | lo_port_drive;

   // Registered so the analog mode controls never glitch on a pin change.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         loPortInputOn <= 1'b1;
         loPortOutputOn <= 1'b0;
         loPortOutputDouble <= 1'b0;
      end else begin
         loPortInputOn <= lo_port_as_input & ~driveWanted;
         loPortOutputOn <= ~lo_port_as_input & driveWanted;
         loPortOutputDouble <= ~lo_port_as_input & driveWanted & lo_double_choice;
      end
   end
endmodule
`default_nettype wire

// *** verilog/sdc_status_mux.sv ***
// Registered selector for the multiplexed status output pin.
`timescale 1ns/100ps
`default_nettype none
module sdc_status_mux (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [sdc_pkg::MUX_SEL_W-1:0] muxSel,
   input wire logic [sdc_pkg::MUX_SRC_N-1:0] statusSources,
   output logic status_mux_pin
);
   // A flop on the pin keeps select changes from making runt pulses.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         status_mux_pin <= 1'b0;
      end else begin
         status_mux_pin <= statusSources[muxSel];
      end
   end
endmodule
`default_nettype wire

// *** test/sdc_config_regs_assertions.sv ***
// Checker for the word port timing and the field decode of the configuration registers.
`timescale 1ns/100ps
`default_nettype none
module sdc_config_regs_assertions (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic wordValid,
   input wire logic [23:0] wordData,
   input wire logic lo_port_select_pin,
   input wire logic ditherOn,
   input wire logic [3:0] ditherMagnitude,
   input wire logic [16:0] ditherSeed,
   input wire logic [1:0] pumpCurrentCode,
   input wire logic pumpUsesResistor,
   input wire logic [4:0] phaseOffsetMult,
   input wire logic phaseOffsetNegative,
   input wire logic [1:0] refScaleCode,
   input wire logic refDoubleOn,
   input wire logic refDivideBy2On,
   input wire logic refDivideBy4On,
   input wire logic modBiasOn,
   input wire logic modOutputOn,
   input wire logic loPortInputOn,
   input wire logic loPortOutputOn,
   input wire logic loPortOutputDouble,
   input wire logic foreignWord
);
   // One clock domain, so clocking and reset are stated once for every property.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // A taken word is sampled on its own outputs two samples later.
   property p_dither;
      wordValid && wordData[2:0] == 3'h3 |-> ##2
         ditherOn == $past(wordData[20], 2) && ditherSeed == $past(wordData[19:3], 2);
   endproperty
   a_dither: assert property (p_dither) else $error("dither fields wrong");
   property p_mag;
      wordValid && wordData[2:0] == 3'h3 |-> ##2
         ditherMagnitude == (4'hf >> $past(wordData[22:21], 2));
   endproperty
   a_mag: assert property (p_mag) else $error("dither magnitude wrong");
   property p_pump;
      wordValid && wordData[2:0] == 3'h4 |-> ##2
         {pumpUsesResistor, phaseOffsetNegative, phaseOffsetMult, pumpCurrentCode} ==
         {$past(wordData[18:12], 2), $past(wordData[11:10], 2)};
   endproperty
   a_pump: assert property (p_pump) else $error("pump fields wrong");
   property p_ref;
      {refDoubleOn, refDivideBy2On, refDivideBy4On} ==
         {refScaleCode == 2'h0, refScaleCode == 2'h2, refScaleCode == 2'h3};
   endproperty
   a_ref: assert property (p_ref) else $error("reference scaling wrong");
   property p_mod;
      wordValid && wordData[2:0] == 3'h5 |-> ##2 modBiasOn == $past(wordData[6], 2) &&
         modOutputOn == ($past(wordData[7], 2) && $past(wordData[6], 2));
   endproperty
   a_mod: assert property (p_mod) else $error("modulator enables wrong");
   property p_lo_in;
      wordValid && wordData[2:0] == 3'h5 && wordData[4:3] == 2'h2 ##1 !lo_port_select_pin
         |=> loPortInputOn;
   endproperty
   a_lo_in: assert property (p_lo_in) else $error("LO port not an input");
   property p_lo_out;
      !(loPortInputOn && loPortOutputOn) && (!loPortOutputDouble || loPortOutputOn);
   endproperty
   a_lo_out: assert property (p_lo_out) else $error("LO port modes clash");
   // The pin is sampled at the edge where the port mode flop takes the new register.
   property p_lo_drive;
      wordValid && wordData[2:0] == 3'h5 && !wordData[4] ##1
         (lo_port_select_pin || $past(wordData[3])) |=>
         loPortOutputOn && !loPortInputOn && loPortOutputDouble == $past(wordData[5], 2);
   endproperty
   a_lo_drive: assert property (p_lo_drive) else $error("LO port not driving");
   property p_foreign;
      wordValid && !(wordData[2:0] inside {3'h3, 3'h4, 3'h5}) |-> ##1 foreignWord;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign word not flagged");
endmodule
`default_nettype wire

// *** test/sdc_host_model.sv ***
// Host model that hands whole words to the configuration port.
`timescale 1ns/100ps
`default_nettype none
module sdc_host_model (
   input wire logic sys_clk,
   output logic wordValid,
   output logic [23:0] wordData
);
   // Idle data is the inverse of the last word, so a stale value never passes for a fresh one.
   initial begin
      wordValid = 1'b0;
      wordData = 24'h000000;
   end
   // Called at a falling edge; more keeps the strobe up for a back-to-back word.
   task automatic send(input logic [23:0] w, input logic more);
      wordValid = 1'b1;
      wordData = w;
      @(negedge sys_clk);
      if (!more) begin
         wordValid = 1'b0;
         wordData = ~w;
      end
   endtask
endmodule
`default_nettype wire

// *** test/test_sdc_config_regs.sv ***
// Self-checking bench for the dither, pump and LO path configuration registers.
`timescale 1ns/100ps
`default_nettype none
module test_sdc_config_regs;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic wordValid, lo_port_select_pin = 1'b0;
   logic [23:0] wordData, w, r3 = 24'h10000b, r4 = 24'h0aa7e4, r5 = 24'h0000d5;
   logic [7:0] statusSources = 8'h00;
   logic ditherOn, pumpUsesResistor, phaseOffsetNegative, refDoubleOn, refDivideBy2On;
   logic refDivideBy4On, status_mux_pin, modBiasOn, modOutputOn, foreignWord;
   logic loPortInputOn, loPortOutputOn, loPortOutputDouble;
   logic [3:0] ditherMagnitude;
   logic [16:0] ditherSeed;
   logic [1:0] pumpCurrentCode, refScaleCode;
   logic [4:0] phaseOffsetMult;
   logic [42:0] seen, q[$];
   logic [1:0] pend = 2'h0;
   logic foreignExp, foreignLate = 1'b0;
   int seed = 59;
   int fail_count = 0;
   int samples_checked = 0;
   sdc_host_model sdc_host_model_i (.sys_clk, .wordValid, .wordData);
   sdc_config_regs sdc_config_regs_i (.*);
   initial forever #5 sys_clk = ~sys_clk;
   // Observed outputs packed in the order the expectation is built; the flag lags one edge.
   assign seen = {foreignLate, ditherOn, ditherMagnitude, ditherSeed, pumpCurrentCode,
      pumpUsesResistor, phaseOffsetMult, phaseOffsetNegative, refScaleCode, refDoubleOn,
      refDivideBy2On, refDivideBy4On, status_mux_pin, modBiasOn, modOutputOn, loPortInputOn,
      loPortOutputOn, loPortOutputDouble};
   // Expected outputs from the three register images, the select pin and the sources.
   function automatic logic [41:0] decode(input logic [23:0] a, b, c, input logic p,
      input logic [7:0] s);
      logic m;
      m = p | c[3];
      decode = {a[20], 4'hf >> a[22:21], a[19:3], b[11:10], b[18], b[16:12], b[17], b[20:19],
         b[20:19] == 2'h0, b[20:19] == 2'h2, b[20:19] == 2'h3, s[b[6:4]], c[6], c[7] & c[6],
         c[4] & ~m, ~c[4] & m, ~c[4] & m & c[5]};
   endfunction
   task automatic check(input logic [42:0] got, input logic [42:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checked %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Fields show one edge after the taking edge, so the note is compared at the next fall.
   always @(posedge sys_clk) pend <= {pend[0], wordValid & ~srst};
   // The one-cycle foreign flag is held one edge so it lines up with the field outputs.
   always @(posedge sys_clk) foreignLate <= foreignWord;
   always @(negedge sys_clk) begin
      if (pend[1] && q.size() > 0) begin
         check(seen, q.pop_front());
      end
   end
   // Hang guard: a run that outlives this bound is a failure.
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      complete_run();
   end
   // Main sequence: a foreign word first shows the reset decode, then random words follow.
   initial begin
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      q.push_back({1'b1, decode(r3, r4, r5, 1'b0, 8'h00)});
      sdc_host_model_i.send(24'h5a5a50, 1'b0);
      for (int i = 0; i < 400; i++) begin
         w = 24'($random(seed));
         if (i % 4 != 3) w[2:0] = 3'h3 + 3'(i % 3);
         // Pin and sources change only after the pending results have been compared.
         if (i % 8 == 0) begin
            repeat (3) @(negedge sys_clk);
            lo_port_select_pin = w[23];
            statusSources = 8'($random(seed));
         end
         foreignExp = 1'b0;
         case (w[2:0])
            3'h3: r3 = w;
            3'h4: r4 = w;
            3'h5: r5 = w;
            default: foreignExp = 1'b1;
         endcase
         q.push_back({foreignExp, decode(r3, r4, r5, lo_port_select_pin, statusSources)});
         sdc_host_model_i.send(w, (i + 1) % 8 != 0 && i != 399);
      end
      repeat (5) @(negedge sys_clk);
      // Every note must have met its result; a leftover means a word was lost.
      check(43'(q.size()), 43'h0);
      complete_run();
   end
endmodule
bind sdc_config_regs sdc_config_regs_assertions sdc_config_regs_assertions_i (.*);
`default_nettype wire
